// ==== hw/dsir_bank.sv ====
// Paged instruction-memory register bank behind a two-wire serial control bus
`timescale 1ns/1ps

// Overview of operation
// [R1] 512 instructions, 16 pages of 32
// [R2] Only pages 32 to 47 reach memory
// [R3] Location 0: 8-bit page select, resets zero
// [R4] Host selects only pages 0,1,4,5,32-47; location 0 accepts and stores any 8-bit value
// [R5] Host writes reserved locations with defaults only
// [R6] 20-bit word over three bytes, top nibble first
// [R7] Instruction n sits at locations 2+3n..4+3n
// [R8] Page p holds instructions (p-32)*32 onward
// [R9] Instruction bytes have no reset value
// [R10] Reads return last written byte or page; reserved locations and instruction bytes of pages outside 32-47 read back 0x00
// [R11] Host writes register number then data byte
module dsir_bank
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic [7:0] page_select_o,
    input wire logic [8:0] dsp_addr_i,
    output logic [19:0] dsp_instr_o
);

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } dsir_state_t;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic scl_s1_reg;
    logic scl_s2_reg;
    logic scl_s3_reg;
    logic sda_s1_reg;
    logic sda_s2_reg;
    logic sda_s3_reg;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_s3_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_s3_reg <= 1'b1;
        end
        else
        begin
            scl_s1_reg <= scl_i;
            scl_s2_reg <= scl_s1_reg;
            scl_s3_reg <= scl_s2_reg;
            sda_s1_reg <= sda_i;
            sda_s2_reg <= sda_s1_reg;
            sda_s3_reg <= sda_s2_reg;
        end
    end

    wire scl_rise = scl_s2_reg && !scl_s3_reg;
    wire scl_fall = !scl_s2_reg && scl_s3_reg;
    wire scl_high = scl_s2_reg && scl_s3_reg;
    wire bus_start = scl_high && sda_s3_reg && !sda_s2_reg;
    wire bus_stop = scl_high && !sda_s3_reg && sda_s2_reg;

    // ----------------------------------------------------------------
    // Protocol state
    // ----------------------------------------------------------------
    dsir_state_t state_reg;
    dsir_state_t state_next;
    logic [3:0] bit_cnt_reg;
    logic [3:0] bit_cnt_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] tx_reg;
    logic [7:0] tx_next;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic rd_mode_reg;
    logic rd_mode_next;
    logic master_ack_reg;
    logic master_ack_next;
    logic sda_oe_reg;
    logic sda_oe_next;
    logic [7:0] page_sel_reg;
    logic [7:0] page_sel_next;
    logic wr_strobe;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire [6:0] loc = ptr_reg[6:0];
    wire loc_valid = !ptr_reg[7];
    wire page_is_ram = (page_sel_reg >= dsir_pkg::FIRST_RAM_PAGE)
        && (page_sel_reg <= dsir_pkg::LAST_RAM_PAGE); // [R2]
    wire loc_is_page = loc_valid && (loc == dsir_pkg::LOC_PAGE_SEL); // [R3]
    // Location 1 and 98 upward fall outside this window and stay inert [R5]
    wire loc_is_instr = loc_valid && (loc >= dsir_pkg::LOC_INSTR_FIRST)
        && (loc <= dsir_pkg::LOC_INSTR_LAST);
    wire [6:0] loc_off = loc - dsir_pkg::LOC_INSTR_FIRST;
    wire [6:0] slot_full = loc_off / dsir_pkg::BYTES_PER_INSTR; // [R7]
    wire [6:0] lane_full = loc_off - slot_full * dsir_pkg::BYTES_PER_INSTR;
    wire [4:0] slot = slot_full[dsir_pkg::SLOT_W-1:0];
    wire [1:0] lane = lane_full[1:0]; // [R6]
    // Page low nibble picks the block of 32 instructions [R8] [R1]
    wire [8:0] instr_idx = {page_sel_reg[3:0], slot};
    wire ram_hit = page_is_ram && loc_is_instr;
    wire ram_we = wr_strobe && ram_hit;
    wire [7:0] ram_rd_data;

    wire [7:0] rd_byte = loc_is_page ? page_sel_reg
        : (ram_hit ? ram_rd_data : dsir_pkg::UNMAPPED_READ); // [R10]

    dsir_instr_mem dsir_instr_mem_inst
    (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .wr_en_i(ram_we),
        .wr_instr_i(instr_idx),
        .wr_lane_i(lane),
        .wr_data_i(shift_reg),
        .rd_instr_i(instr_idx),
        .rd_lane_i(lane),
        .rd_data_o(ram_rd_data),
        .dsp_addr_i(dsp_addr_i),
        .dsp_instr_o(dsp_instr_o)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        ptr_next = ptr_reg;
        rd_mode_next = rd_mode_reg;
        master_ack_next = master_ack_reg;
        sda_oe_next = sda_oe_reg;
        page_sel_next = page_sel_reg;
        wr_strobe = 1'b0;
        if (bus_start)
        begin
            // Repeated start keeps the pointer for a following read
            state_next = ST_ADDR;
            bit_cnt_next = 4'h0;
            sda_oe_next = 1'b0;
        end
        else if (bus_stop)
        begin
            state_next = ST_IDLE;
            sda_oe_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_ADDR, ST_PTR, ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shift_next = {shift_reg[6:0], sda_s2_reg};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_reg == dsir_pkg::BITS_PER_BYTE)
                    begin
                        sda_oe_next = 1'b1;
                        if (state_reg == ST_ADDR)
                        begin
                            if (shift_reg[7:1] == dsir_pkg::DEV_ADDR) // [R11]
                            begin
                                rd_mode_next = shift_reg[0];
                                state_next = ST_ADDR_ACK;
                            end
                            else
                            begin
                                sda_oe_next = 1'b0;
                                state_next = ST_IDLE;
                            end
                        end
                        else if (state_reg == ST_PTR)
                        begin
                            ptr_next = shift_reg; // [R11]
                            state_next = ST_PTR_ACK;
                        end
                        else
                        begin
                            wr_strobe = 1'b1;
                            if (loc_is_page)
                                page_sel_next = shift_reg; // [R3]
                            state_next = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_next = 4'h0;
                        if (rd_mode_reg)
                        begin
                            tx_next = rd_byte;
                            sda_oe_next = !rd_byte[7];
                            ptr_next = ptr_reg + 8'h01;
                            state_next = ST_RDATA;
                        end
                        else
                        begin
                            sda_oe_next = 1'b0;
                            state_next = ST_PTR;
                        end
                    end
                end
                ST_PTR_ACK, ST_WDATA_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_next = 1'b0;
                        bit_cnt_next = 4'h0;
                        if (state_reg == ST_WDATA_ACK)
                            ptr_next = ptr_reg + 8'h01;
                        state_next = ST_WDATA;
                    end
                end
                ST_RDATA:
                begin
                    if (scl_rise)
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    else if (scl_fall)
                    begin
                        if (bit_cnt_reg == dsir_pkg::BITS_PER_BYTE)
                        begin
                            sda_oe_next = 1'b0;
                            state_next = ST_RDATA_ACK;
                        end
                        else
                        begin
                            tx_next = {tx_reg[6:0], 1'b0};
                            sda_oe_next = !tx_reg[6];
                        end
                    end
                end
                ST_RDATA_ACK:
                begin
                    if (scl_rise)
                        master_ack_next = !sda_s2_reg;
                    else if (scl_fall)
                    begin
                        bit_cnt_next = 4'h0;
                        if (master_ack_reg)
                        begin
                            tx_next = rd_byte;
                            sda_oe_next = !rd_byte[7];
                            ptr_next = ptr_reg + 8'h01;
                            state_next = ST_RDATA;
                        end
                        else
                            state_next = ST_IDLE;
                    end
                end
                ST_IDLE:
                begin
                    sda_oe_next = 1'b0;
                end
                default:
                begin
                    state_next = ST_IDLE;
                    sda_oe_next = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rd_mode_reg <= 1'b0;
            master_ack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            page_sel_reg <= dsir_pkg::PAGE_SEL_RESET; // [R3]
        end
        else
        begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            ptr_reg <= ptr_next;
            rd_mode_reg <= rd_mode_next;
            master_ack_reg <= master_ack_next;
            sda_oe_reg <= sda_oe_next;
            page_sel_reg <= page_sel_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Open drain: the data line is only ever pulled low
    always_ff @(posedge mclk_i)
    begin
        sda_o <= 1'b0;
    end

    assign sda_oe_o = sda_oe_reg;
    assign page_select_o = page_sel_reg;

endmodule

// ==== hw/dsir_pkg.sv ====
// Package of constants for the paged signal-processor instruction memory
package dsir_pkg;

    // ----------------------------------------------------------------
    // Serial control bus
    // ----------------------------------------------------------------
    localparam logic [7:0] DEV_ADDR_WRITE = 8'h30;
    localparam logic [6:0] DEV_ADDR = DEV_ADDR_WRITE[7:1];
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ----------------------------------------------------------------
    // Page map
    // ----------------------------------------------------------------
    localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
    localparam logic [7:0] FIRST_RAM_PAGE = 8'h20;
    localparam logic [7:0] LAST_RAM_PAGE = 8'h2F;
    localparam int NUM_PAGES = 16;
    localparam int INSTR_PER_PAGE = 32;
    localparam int NUM_INSTR = NUM_PAGES * INSTR_PER_PAGE;
    localparam int INSTR_AW = 9;
    localparam int SLOT_W = 5;

    // ----------------------------------------------------------------
    // Locations within a page
    // ----------------------------------------------------------------
    localparam logic [6:0] LOC_PAGE_SEL = 7'h00;
    localparam logic [6:0] LOC_RSVD_ONE = 7'h01;
    localparam logic [6:0] LOC_INSTR_FIRST = 7'h02;
    localparam logic [6:0] LOC_INSTR_LAST = 7'h61;
    localparam logic [6:0] LOC_RSVD_UPPER = 7'h62;
    localparam logic [6:0] BYTES_PER_INSTR = 7'h03;

    // ----------------------------------------------------------------
    // Instruction word layout
    // ----------------------------------------------------------------
    localparam int INSTR_W = 20;
    localparam int NUM_LANES = 3;
    localparam logic [1:0] LANE_TOP = 2'h0;
    localparam logic [1:0] LANE_MID = 2'h1;
    localparam logic [1:0] LANE_LOW = 2'h2;
    localparam int TOP_NIBBLE_W = 4;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

// ==== hw/dsir_instr_mem.sv ====
// Instruction storage: three byte lanes of 512 entries each
`timescale 1ns/1ps

module dsir_instr_mem
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [8:0] wr_instr_i,
    input wire logic [1:0] wr_lane_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [8:0] rd_instr_i,
    input wire logic [1:0] rd_lane_i,
    output logic [7:0] rd_data_o,
    input wire logic [8:0] dsp_addr_i,
    output logic [19:0] dsp_instr_o
);

    logic [7:0] lane_rd [dsir_pkg::NUM_LANES];
    logic [7:0] lane_dsp [dsir_pkg::NUM_LANES];
    logic [1:0] rd_lane_reg;

    // ----------------------------------------------------------------
    // Byte lanes
    // ----------------------------------------------------------------
    // No reset on the arrays: contents are undefined until loaded [R9]
    for (genvar g = 0; g < dsir_pkg::NUM_LANES; g++)
    begin : g_lane
        logic [7:0] mem [dsir_pkg::NUM_INSTR];
        wire lane_we = wr_en_i && (wr_lane_i == 2'(g));

        always_ff @(posedge mclk_i)
        begin
            if (lane_we)
                mem[wr_instr_i] <= wr_data_i; // [R10]
            lane_rd[g] <= mem[rd_instr_i];
            lane_dsp[g] <= mem[dsp_addr_i];
        end
    end

    // ----------------------------------------------------------------
    // Read selection
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            rd_lane_reg <= dsir_pkg::LANE_TOP;
        else
            rd_lane_reg <= rd_lane_i;
    end

    assign rd_data_o = lane_rd[rd_lane_reg];
    // Upper nibble of the top lane is kept for readback but never executed
    assign dsp_instr_o = {lane_dsp[dsir_pkg::LANE_TOP][dsir_pkg::TOP_NIBBLE_W-1:0],
        lane_dsp[dsir_pkg::LANE_MID], lane_dsp[dsir_pkg::LANE_LOW]}; // [R6]

endmodule

// ==== tb/dsir_host.sv ====
// Host controller model driving the two-wire serial control bus
`timescale 1ns/1ps

module dsir_host
(
    input wire logic mclk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    int nack_count = 0;

    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // ----------------------------------------------------------------
    // Bus phases: SCL low and high are 20 mclk each, well above the minimum
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic bit_slot(input logic b, output logic s);
        sda_low_o <= !b;
        tick(10);
        scl_o <= 1'b1;
        tick(10);
        s = sda_i;
        tick(10);
        scl_o <= 1'b0;
        tick(10);
    endtask

    // SDA is released before SCL rises, so a repeated start is never seen as a stop
    task automatic start_cond();
        sda_low_o <= 1'b0;
        tick(10);
        scl_o <= 1'b1;
        tick(20);
        sda_low_o <= 1'b1;
        tick(20);
        scl_o <= 1'b0;
        tick(10);
    endtask

    task automatic stop_cond();
        sda_low_o <= 1'b1;
        tick(10);
        scl_o <= 1'b1;
        tick(20);
        sda_low_o <= 1'b0;
        tick(20);
    endtask

    task automatic send_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_slot(b[i], s);
        bit_slot(1'b1, s);
        if (s !== 1'b0)
            nack_count++;
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
        start_cond();
        send_byte(dsir_pkg::DEV_ADDR_WRITE);
        send_byte(ptr);
        foreach (d[i])
            send_byte(d[i]);
        stop_cond();
    endtask

    // Single-byte read; the final NACK ends the transfer
    task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
        logic s;
        start_cond();
        send_byte(dsir_pkg::DEV_ADDR_WRITE);
        send_byte(ptr);
        start_cond();
        send_byte({dsir_pkg::DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--)
            bit_slot(1'b1, d[i]);
        bit_slot(1'b1, s);
        stop_cond();
    endtask
endmodule

// ==== tb/dsir_bank_sva.sv ====
// Concurrent checks on the ports of the instruction register bank
`timescale 1ns/1ps

module dsir_bank_sva
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic [7:0] page_select_o,
    input wire logic [8:0] dsp_addr_i,
    input wire logic [19:0] dsp_instr_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    sequence ack_begin;
        $rose(sda_oe_o);
    endsequence

    sequence ack_hold;
        sda_oe_o [*8];
    endsequence

    a_page_reset_zero: assert property (disable iff (1'b0) rst_i |=> page_select_o == 8'h00)
        else $error("page select not cleared by reset");
    a_release_reset: assert property (disable iff (1'b0) rst_i |=> !sda_oe_o)
        else $error("data line driven during reset");
    a_page_scl_low: assert property ($changed(page_select_o) |-> !scl_i)
        else $error("page select changed while clock high");
    a_drive_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data drive changed while clock high");
    a_drive_value_zero: assert property (sda_oe_o |-> !sda_o)
        else $error("data line driven high");
    a_ack_min_width: assert property (ack_begin |-> ack_hold)
        else $error("acknowledge too short");
    a_ack_released: assert property (ack_begin |-> ##[1:1000] !sda_oe_o)
        else $error("data line never released");
    // Fetch output moves only after an address change or during a bus store
    a_fetch_cause: assert property ($changed(dsp_instr_o) |->
        ($past(dsp_addr_i) != $past(dsp_addr_i, 2)) || !scl_i)
        else $error("instruction output changed without cause");
endmodule

bind dsir_bank dsir_bank_sva dsir_bank_sva_inst
(
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .page_select_o(page_select_o),
    .dsp_addr_i(dsp_addr_i),
    .dsp_instr_o(dsp_instr_o)
);

// ==== tb/dsir_bank_tb.sv ====
// Self-checking testbench for the paged instruction register bank
`timescale 1ns/1ps

module dsir_bank_tb;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [8:0] dsp_addr_i = 9'h000;
    logic scl;
    logic host_low;
    logic sda_oe;
    logic sda_drv;
    logic [7:0] page_sel;
    logic [7:0] rd_byte;
    logic [19:0] instr;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    // Pull-up wire: low when either party pulls it
    wire logic sda = (sda_oe ? sda_drv : 1'b1) & !host_low;
    logic [7:0] pg [4] = '{8'h20, 8'h20, 8'h2F, 8'h21};
    logic [6:0] lc [4] = '{7'h02, 7'h5F, 7'h5F, 7'h02};
    logic [8:0] ix [4] = '{9'h000, 9'h01F, 9'h1FF, 9'h020};
    logic [19:0] wd [4] = '{20'h53C7E, 20'h12345, 20'hFEDCB, 20'h65432};

    always #2.5 mclk_i = ~mclk_i;

    dsir_bank dsir_bank_inst
    (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .scl_i(scl),
        .sda_i(sda),
        .sda_o(sda_drv),
        .sda_oe_o(sda_oe),
        .page_select_o(page_sel),
        .dsp_addr_i(dsp_addr_i),
        .dsp_instr_o(instr)
    );

    dsir_host dsir_host_inst
    (
        .mclk_i(mclk_i),
        .sda_i(sda),
        .scl_o(scl),
        .sda_low_o(host_low)
    );

    // ----------------------------------------------------------------
    // Check helpers
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rb(input logic [7:0] ptr, input logic [7:0] exp);
        dsir_host_inst.rd(ptr, rd_byte);
        chk("read byte", {12'h000, exp}, {12'h000, rd_byte});
    endtask

    task automatic dsp_chk(input logic [8:0] a, input logic [19:0] e);
        dsp_addr_i <= a;
        repeat (3) @(posedge mclk_i);
        chk("dsp_instr_o", e, instr);
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Ceiling is about twice the expected run
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            failures++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge mclk_i);
        chk("page_select_o", 20'h00000, {12'h000, page_sel});
        for (int i = 0; i < 4; i++)
        begin
            dsir_host_inst.wr(8'h00, '{pg[i]});
            chk("page_select_o", {12'h000, pg[i]}, {12'h000, page_sel});
            dsir_host_inst.wr({1'b0, lc[i]}, '{{4'h5, wd[i][19:16]}, wd[i][15:8], wd[i][7:0]});
        end
        for (int i = 0; i < 4; i++)
            dsp_chk(ix[i], wd[i]);
        for (int i = 0; i < 4; i++)
        begin
            dsir_host_inst.wr(8'h00, '{pg[i]});
            rb({1'b0, lc[i]}, {4'h5, wd[i][19:16]});
            rb({1'b0, lc[i]} + 8'h01, wd[i][15:8]);
            rb({1'b0, lc[i]} + 8'h02, wd[i][7:0]);
        end
        rb(8'h00, 8'h21);
        // Page 1 shares its low nibble with page 33, so a leak would hit instruction 32
        dsir_host_inst.wr(8'h00, '{8'h01});
        dsir_host_inst.wr(8'h02, '{8'h0F, 8'hFF, 8'hFF});
        dsp_chk(9'h000, wd[0]);
        dsp_chk(9'h020, wd[3]);
        rb(8'h02, 8'h00);
        rb(8'h00, 8'h01);
        rst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge mclk_i);
        chk("page_select_o", 20'h00000, {12'h000, page_sel});
        rb(8'h00, 8'h00);
        chk("nack count", 20'h00000, 20'(dsir_host_inst.nack_count));
        final_report();
    end
endmodule
